// File: rtl/occ_osc_ctrl.sv
//==========================================================================
// Oscillator control block
//==========================================================================
// Purpose: AHB-Lite oscillator control register, internal divider,
//          source switch and power-managed clock gating
// Assumes: Oscillator levels and status inputs come from other domains
// Notes:   Zero-wait-state slave, always OKAY
//
// How it works
// - Eight-bit register: idle, freq, two status, source
// - Idle keeps peripherals clocked; otherwise CPU and peripheral enables both drop
// - Freq code picks 8 MHz down to slow
// - Startup bit shows primary start-up timer expiry
// - Source select: 1x internal, 01 secondary, 00 primary
`timescale 1ns/1ps
module occ_osc_ctrl
   import occ_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Oscillator levels and status from outside
   input wire logic primary_osc_in,
   input wire logic secondary_osc_in,
   input wire logic internal_fast_osc,
   input wire logic internal_slow_rc,
   input wire logic startup_expired_in,
   input wire logic int_osc_stable_in,
   // Power management
   input wire logic pm_enter,
   input wire logic pm_wake,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   // Clock results
   output logic internal_clk_out,
   output logic sysclk_out
);

   // ======================================================================
   // Input synchronisers
   // ======================================================================
   logic [5:0] sync1_r, sync2_r;
   logic [5:0] async_in;
   assign async_in = {int_osc_stable_in, startup_expired_in, internal_slow_rc,
                      internal_fast_osc, secondary_osc_in, primary_osc_in};

   // Two flops per outside input
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end
      else
      begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
      end
   end

   logic prim_s, sec_s, fast_s, slow_s, startup_s, stable_s;
   assign {stable_s, startup_s, slow_s, fast_s, sec_s, prim_s} = sync2_r;

   // ======================================================================
   // AHB-Lite slave and register
   // ======================================================================
   logic [7:0] ctrl_r, ctrl_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [7:0] ctrl_view;
   logic take;

   // Address phase accepted
   assign take = hsel && htrans[1] && hready;

   // Read view: writable bits from storage, status bits live
   always_comb
   begin
      ctrl_view = ctrl_r & OCC_WR_MASK;
      ctrl_view[OCC_STARTUP_BIT] = startup_s;
      ctrl_view[OCC_STABLE_BIT] = stable_s;
   end

   // Decode, write in data phase, read data registered at address phase
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      wr_pend_nxt = 1'b0;
      hrdata_nxt = hrdata_r;
      if (wr_pend_r)
         ctrl_nxt = (ctrl_r & ~OCC_WR_MASK) | (hwdata[7:0] & OCC_WR_MASK);
      if (take)
      begin
         wr_pend_nxt = hwrite && (haddr == OCC_OSC_CTRL_ADDR);
         if (!hwrite && haddr == OCC_OSC_CTRL_ADDR)
            hrdata_nxt = {24'h00_0000, ctrl_view};
         else
            hrdata_nxt = 32'h0000_0000;
      end
   end

   // Register state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_r <= OCC_OSC_CTRL_RST;
         wr_pend_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         wr_pend_r <= wr_pend_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = OCC_HRESP_OKAY;
   assign hrdata = hrdata_r;

   // ======================================================================
   // Internal oscillator block divider
   // ======================================================================
   logic [OCC_DIV_W-1:0] div_r, div_nxt;
   logic fast_d_r, fast_d_nxt;
   logic int_r, int_nxt;
   logic [2:0] freq_code;
   logic [2:0] tap;

   assign freq_code = ctrl_r[OCC_FREQ_HI:OCC_FREQ_LO];
   assign tap = 3'h6 - freq_code;

   // Count fast oscillator rising edges; each bit halves the frequency
   always_comb
   begin
      fast_d_nxt = fast_s;
      div_nxt = div_r;
      if (fast_s && !fast_d_r)
         div_nxt = div_r + 6'h01;
      if (freq_code == OCC_FREQ_8M)
         int_nxt = fast_s;
      else if (freq_code == OCC_FREQ_SLOW)
         int_nxt = slow_s;
      else
         int_nxt = div_r[tap];
   end

   // Divider registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_r <= 6'h00;
         fast_d_r <= 1'b0;
         int_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         fast_d_r <= fast_d_nxt;
         int_r <= int_nxt;
      end
   end

   assign internal_clk_out = int_r;

   // ======================================================================
   // Source switch
   // ======================================================================
   occ_src_t src_req;
   assign src_req = ctrl_r[OCC_SRC_HI] ? OCC_SRC_INTERNAL :
                    (ctrl_r[OCC_SRC_LO] ? OCC_SRC_SECONDARY : OCC_SRC_PRIMARY);

   occ_clk_switch u_switch
   (
      .clk(clk),
      .rst(rst),
      .src_req(src_req),
      .src_lvl({int_r, sec_s, prim_s}),
      .sysclk_out(sysclk_out),
      .switching()
   );

   // ======================================================================
   // Power-managed modes
   // ======================================================================
   logic pm_r, pm_nxt;
   logic idle_r, idle_nxt;

   // Enter on request, leave on wake; idle choice captured at entry
   always_comb
   begin
      pm_nxt = pm_r;
      idle_nxt = idle_r;
      if (pm_wake)
         pm_nxt = 1'b0;
      else if (pm_enter)
      begin
         pm_nxt = 1'b1;
         idle_nxt = ctrl_r[OCC_IDLE_BIT];
      end
   end

   // Power mode registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pm_r <= 1'b0;
         idle_r <= 1'b0;
      end
      else
      begin
         pm_r <= pm_nxt;
         idle_r <= idle_nxt;
      end
   end

   assign cpu_clk_en = !pm_r;
   assign periph_clk_en = !pm_r || idle_r;

   // ======================================================================
   // Checks
   // ======================================================================
   a_status_ignore: assert property (@(posedge clk) disable iff (rst)
      wr_pend_r ##1 1'b1 |-> ctrl_r[3:2] == $past(ctrl_r[3:2]))
      else $error("status bit positions took write data");

   a_write_lands: assert property (@(posedge clk) disable iff (rst)
      wr_pend_r |=> ctrl_r[7:4] == $past(hwdata[7:4]) && ctrl_r[1:0] == $past(hwdata[1:0]))
      else $error("writable bits did not store write data");

   a_idle_sleep: assert property (@(posedge clk) disable iff (rst)
      (pm_enter && !pm_wake && !pm_r) |=> !cpu_clk_en && periph_clk_en == $past(ctrl_r[7]))
      else $error("wrong clock gating on power-managed entry");

   a_freq_fast: assert property (@(posedge clk) disable iff (rst)
      freq_code == OCC_FREQ_8M |=> int_r == $past(fast_s))
      else $error("8 MHz code does not pass fast oscillator");

   a_freq_slow: assert property (@(posedge clk) disable iff (rst)
      freq_code == OCC_FREQ_SLOW |=> int_r == $past(slow_s))
      else $error("code zero does not pass slow source");

   a_startup_read: assert property (@(posedge clk) disable iff (rst)
      (take && !hwrite && haddr == OCC_OSC_CTRL_ADDR) |=> hrdata[3] == $past(startup_s))
      else $error("startup bit read mismatch");

   a_stable_reset: assert property (@(posedge clk)
      rst |=> ctrl_view[OCC_STABLE_BIT] == 1'b0)
      else $error("stable bit not clear after reset");

endmodule // occ_osc_ctrl

// File: rtl/occ_pkg.sv
//==========================================================================
// Oscillator control package
//==========================================================================
// Purpose: Offsets, field positions, reset values and codes for the
//          oscillator control block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   Shared by the main block and the source switch
package occ_pkg;

   // Register map
   localparam logic [31:0] OCC_OSC_CTRL_ADDR = 32'h0000_0000;
   localparam logic [7:0] OCC_OSC_CTRL_RST = 8'h00;

   // Field positions inside oscillator_control
   localparam int OCC_IDLE_BIT = 7;
   localparam int OCC_FREQ_HI = 6;
   localparam int OCC_FREQ_LO = 4;
   localparam int OCC_STARTUP_BIT = 3;
   localparam int OCC_STABLE_BIT = 2;
   localparam int OCC_SRC_HI = 1;
   localparam int OCC_SRC_LO = 0;

   // Writable bits; status bits never take write data
   localparam logic [7:0] OCC_WR_MASK = 8'hF3;

   // Internal frequency select codes
   localparam logic [2:0] OCC_FREQ_8M = 3'h7;
   localparam logic [2:0] OCC_FREQ_SLOW = 3'h0;

   // Divider width for the internal block (8 MHz down to 125 kHz)
   localparam int OCC_DIV_W = 6;

   // System clock source choices
   typedef enum logic [1:0]
   {
      OCC_SRC_PRIMARY = 2'h0,
      OCC_SRC_SECONDARY = 2'h1,
      OCC_SRC_INTERNAL = 2'h2
   } occ_src_t;

   // AHB transfer types and response
   localparam logic [1:0] OCC_HTRANS_NONSEQ = 2'h2;
   localparam logic OCC_HRESP_OKAY = 1'b0;

endpackage

// File: rtl/occ_clk_switch.sv
//==========================================================================
// Glitch-free system clock source switch
//==========================================================================
// Purpose: Moves the system clock between three sampled sources
// Assumes: Source levels are already synchronised to clk
// Notes:   The output parks low between sources so no runt appears
`timescale 1ns/1ps
module occ_clk_switch
   import occ_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Source choice and levels
   input wire occ_src_t src_req,
   input wire logic [2:0] src_lvl,
   // Switched clock and switch-in-progress flag
   output logic sysclk_out,
   output logic switching
);

   typedef enum logic {OCC_SW_RUN = 1'b0, OCC_SW_PARK = 1'b1} occ_sw_state_t;

   occ_sw_state_t state_r, state_nxt;
   occ_src_t cur_r, cur_nxt;
   logic out_r, out_nxt;

   // Level of a source by its choice code
   function automatic logic src_level(input occ_src_t s, input logic [2:0] lvl);
      unique case (s)
         OCC_SRC_PRIMARY: src_level = lvl[0];
         OCC_SRC_SECONDARY: src_level = lvl[1];
         default: src_level = lvl[2];
      endcase
   endfunction

   // Leave the old source only while low, join the new one while low
   always_comb
   begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      out_nxt = out_r;
      unique case (state_r)
         OCC_SW_RUN:
         begin
            out_nxt = src_level(cur_r, src_lvl);
            if (src_req != cur_r && !src_level(cur_r, src_lvl))
            begin
               state_nxt = OCC_SW_PARK;
               out_nxt = 1'b0;
            end
         end
         OCC_SW_PARK:
         begin
            out_nxt = 1'b0;
            if (!src_level(src_req, src_lvl))
            begin
               cur_nxt = src_req;
               state_nxt = OCC_SW_RUN;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r <= OCC_SW_RUN;
         cur_r <= OCC_SRC_PRIMARY;
         out_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         out_r <= out_nxt;
      end
   end

   assign sysclk_out = out_r;
   assign switching = (state_r == OCC_SW_PARK);

   // Output rises only while running on a source whose level was high
   a_no_runt_pulse: assert property (@(posedge clk) disable iff (rst)
      $rose(out_r) |-> $past(state_r) == OCC_SW_RUN && $past(src_level(cur_r, src_lvl)))
      else $error("system clock rose during a source change");

   // A settled switch follows the requested source level
   a_source_follow: assert property (@(posedge clk) disable iff (rst)
      (state_r == OCC_SW_RUN && src_req == cur_r) ##1 (state_r == OCC_SW_RUN)
      |-> out_r == $past(src_level(cur_r, src_lvl)))
      else $error("system clock does not follow selected source");

endmodule // occ_clk_switch

// File: verification/tb_top.sv
//==========================================================================
// Oscillator control testbench
//==========================================================================
// Purpose: Drives the oscillator control block over AHB-Lite and checks it
// Assumes: Zero-wait slave, register at byte address 0x0
// Notes:   Oscillator levels come from one free-running counter
`timescale 1ns/1ps
module tb_top
   import occ_pkg::*;
;
   // Clock, reset and bus
   logic clk, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   // Status, power and clock results
   logic startup_expired_in, int_osc_stable_in, pm_enter, pm_wake;
   logic cpu_clk_en, periph_clk_en, internal_clk_out, sysclk_out;
   logic [7:0] osc_cnt;
   int n_errors, total_checks, cyc, r;

   occ_osc_ctrl i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .primary_osc_in(osc_cnt[2]), .secondary_osc_in(osc_cnt[3]),
      .internal_fast_osc(osc_cnt[1]), .internal_slow_rc(osc_cnt[5]),
      .startup_expired_in(startup_expired_in), .int_osc_stable_in(int_osc_stable_in),
      .pm_enter(pm_enter), .pm_wake(pm_wake), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .internal_clk_out(internal_clk_out),
      .sysclk_out(sysclk_out));

   //=======================================================================
   // Clock, oscillator counter and timeout
   //=======================================================================
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Periods: fast 4, primary 8, secondary 16, slow 64 clocks
   always @(posedge clk)
   begin
      osc_cnt <= osc_cnt + 8'h01;
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         $display("Timeout after %0d cycles", cyc);
         finish_test();
      end
   end

   //=======================================================================
   // Checking and bus tasks
   //=======================================================================
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_near(input string name, input int exp, input int got);
      total_checks++;
      if (got < exp - 2 || got > exp + 2)
      begin
         n_errors++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // One single transfer: address phase, then data phase
   task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= addr;
      htrans <= OCC_HTRANS_NONSEQ;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
      chk("hresp", OCC_HRESP_OKAY, hresp);
   endtask

   task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
      ahb_xfer(1'b0, addr, 32'h0000_0000);
      chk(name, exp, rd);
   endtask

   // Rising edges of one clock result over n cycles
   task automatic count_rises(input logic use_sys, input int n, output int cnt);
      logic prev, s;
      cnt = 0;
      prev = 1'b1;
      repeat (n)
      begin
         @(posedge clk);
         s = use_sys ? sysclk_out : internal_clk_out;
         if (s === 1'b1 && prev === 1'b0)
            cnt++;
         prev = s;
      end
   endtask

   // Enter power-managed mode with the given register value, then wake
   task automatic pm_cycle(input logic [31:0] v, input logic exp_per);
      ahb_xfer(1'b1, 32'h0000_0000, v);
      pm_enter <= 1'b1;
      @(posedge clk);
      pm_enter <= 1'b0;
      @(posedge clk);
      chk("cpu_clk_en", 32'h0, {31'h0, cpu_clk_en});
      chk("periph_clk_en", {31'h0, exp_per}, {31'h0, periph_clk_en});
      pm_wake <= 1'b1;
      @(posedge clk);
      pm_wake <= 1'b0;
      @(posedge clk);
      chk("woken", 32'h3, {30'h0, cpu_clk_en, periph_clk_en});
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   //=======================================================================
   // Test sequence
   //=======================================================================
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pm_enter = 1'b0;
      pm_wake = 1'b0;
      startup_expired_in = 1'b0;
      int_osc_stable_in = 1'b0;
      osc_cnt = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk("reset value", 32'h0, 32'h0000_0000);
      $display("Test reset done");
      ahb_xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
      rd_chk("status bits kept", 32'h0, 32'h0000_00F3);
      ahb_xfer(1'b1, 32'h4, 32'h0000_0000);
      rd_chk("unmapped read", 32'h4, 32'h0000_0000);
      rd_chk("unmapped write", 32'h0, 32'h0000_00F3);
      $display("Test access done");
      ahb_xfer(1'b1, 32'h0, 32'h0);
      startup_expired_in <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk("startup done", 32'h0, 32'h0000_0008);
      startup_expired_in <= 1'b0;
      int_osc_stable_in <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk("osc stable", 32'h0, 32'h0000_0004);
      int_osc_stable_in <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk("status clear", 32'h0, 32'h0000_0000);
      $display("Test status done");
      for (int c = 0; c < 8; c++)
      begin
         ahb_xfer(1'b1, 32'h0, 32'(c << 4));
         rd_chk("freq code", 32'h0, 32'(c << 4));
         repeat (300) @(posedge clk);
         count_rises(1'b0, 1024, r);
         chk_near("internal rises", (c == 0) ? 16 : 1024 / (4 << (7 - c)), r);
      end
      $display("Test frequency done");
      for (int s = 0; s < 4; s++)
      begin
         ahb_xfer(1'b1, 32'h0, 32'h70 | 32'(s));
         repeat (64) @(posedge clk);
         count_rises(1'b1, 512, r);
         chk_near("sysclk rises", (s > 1) ? 128 : (s == 1) ? 32 : 64, r);
      end
      $display("Test source done");
      pm_cycle(32'h0000_0080, 1'b1);
      pm_cycle(32'h0000_0000, 1'b0);
      $display("Test power done");
      // Mid-run reset clears the register; stable bit then reads live
      int_osc_stable_in <= 1'b1;
      ahb_xfer(1'b1, 32'h0, 32'h0000_0083);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk("mid-run reset", 32'h0, 32'h0000_0004);
      $display("Test reset again done");
      finish_test();
   end

endmodule // tb_top
